// >>> smc_defs.svh
/*
 Constants for the sleep mode controller: mode codes, register offsets,
 field positions, reset values and timing counts.
 Assumes a 10 MHz system clock.
*/
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

`define SMC_CLK_MHZ          10
`define SMC_MODE_IDLE        2'h0
`define SMC_MODE_NOISE       2'h1
`define SMC_MODE_PDOWN       2'h2
`define SMC_MODE_PSAVE       2'h3

`define SMC_ADDR_SLEEP_CTRL  12'h000
`define SMC_ADDR_CORE_CTRL   12'h004
`define SMC_ADDR_WAKE_CFG    12'h008
`define SMC_ADDR_STATUS      12'h00c

`define SMC_SE_BIT           0
`define SMC_SM_LO            1
`define SMC_BROWNOUT_OFF_IN_SLEEP_BIT         6
`define SMC_BROWNOUT_OFF_UNLOCK_BIT        5
`define SMC_AS0_BIT          0
`define SMC_GIE_BIT          1
`define SMC_EXT_IRQ_ZERO_LVL_BIT     2
`define SMC_EXT_IRQ_ONE_LVL_BIT     3
`define SMC_T0_OVF_EN_BIT    4
`define SMC_T0_CMP_EN_BIT    5
`define SMC_ADC_EN_BIT       6
`define SMC_SLEEP_CTRL_RST   8'h00
`define SMC_CORE_CTRL_RST    8'h00
`define SMC_WAKE_CFG_RST     8'h00

`define SMC_UNLOCK_WIN       3'h4
`define SMC_BROWNOUT_OFF_IN_SLEEP_DELAY       3'h3
`define SMC_BROWNOUT_OFF_IN_SLEEP_HOLD        3'h3
`define SMC_IRQ_HALT         16'h0004
`define SMC_BOD_WAKE_US      60
`define SMC_BOD_WAKE_CYC     16'(`SMC_BOD_WAKE_US * `SMC_CLK_MHZ)
`define SMC_STARTUP_UNIT     16'h0040

`endif

// >>> smc_pkg.sv
/*
 Types for the sleep mode controller.
 Assumes smc_defs.svh holds the numeric constants.
*/
package smc_pkg;
  typedef enum logic [1:0] {SMC_ACTIVE, SMC_SLEEP, SMC_WAKE} smc_state_t;
endpackage : smc_pkg

// >>> smc_sleep_ctrl.sv
/*
 Sleep mode controller: APB registers, sleep entry, clock domain gating,
 wake source filtering, brown-out disable sequence and wake-up delay.
 Assumes a core that pulses sleep_instr and waits on core_run, and a
 10 MHz sys_clk with active-low asynchronous nrst.
*/
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "smc_defs.svh"

module smc_sleep_ctrl (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Core handshake
  input  wire logic        sleep_instr,
  input  wire logic        irq_pending,
  output logic             core_run,
  // Wake sources
  input  wire logic        ext_irq_zero,
  input  wire logic        ext_irq_one,
  input  wire logic        pin_change,
  input  wire logic        wdt_event,
  input  wire logic        start_detect,
  input  wire logic        conv_done,
  input  wire logic        nvm_ready,
  input  wire logic        timer0_ovf,
  input  wire logic        timer0_cmp,
  input  wire logic        other_io_irq,
  input  wire logic [3:0]  clock_source_fuses,
  // Clock domain enables
  output logic             core_clock_domain,
  output logic             flash_clock_domain,
  output logic             io_clock_domain,
  output logic             converter_clock_domain,
  output logic             async_clock_domain,
  output logic             main_osc_en,
  output logic             timer0_osc_en,
  output logic             brownout_detector_en,
  output logic             conv_start
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0]              sleep_control_reg;
  logic [7:0]              wake_cfg;
  logic                    brownout_off_in_sleep;
  logic [2:0]              unlock_cnt;
  logic [2:0]              brownout_off_in_sleep_cnt;
  logic                    brownout_off_in_sleep_active;
  smc_pkg::smc_state_t     state;
  logic [1:0]              mode;
  logic                    bod_was_off;
  logic [15:0]             wake_cnt;

  logic                    wr_en;
  logic                    rd_en;
  logic                    sleep_go;
  logic                    wake_req;
  logic [7:0]              core_wdata;
  logic                    deep_mode;

  assign wr_en      = psel && penable && pwrite;
  assign rd_en      = psel && penable && !pwrite;
  assign core_wdata = pwdata[7:0];
  assign sleep_go   = sleep_instr && sleep_control_reg[`SMC_SE_BIT] && state == smc_pkg::SMC_ACTIVE;
  assign deep_mode  = sleep_control_reg[`SMC_SM_LO+1];

  // Wake source filter per sleep mode
  function automatic logic wake_ok(input logic [1:0] m, input logic [7:0] cfg);
    logic lvl;
    logic t0;
    lvl = (ext_irq_zero && cfg[`SMC_EXT_IRQ_ZERO_LVL_BIT]) || (ext_irq_one && cfg[`SMC_EXT_IRQ_ONE_LVL_BIT]);
    t0  = cfg[`SMC_AS0_BIT] && cfg[`SMC_GIE_BIT] &&
          ((timer0_ovf && cfg[`SMC_T0_OVF_EN_BIT]) || (timer0_cmp && cfg[`SMC_T0_CMP_EN_BIT]));
    wake_ok = 1'b0;
    case (m)
      `SMC_MODE_IDLE: wake_ok = ext_irq_zero || ext_irq_one || pin_change || wdt_event || start_detect ||
                                conv_done || nvm_ready || timer0_ovf || timer0_cmp || other_io_irq;
      `SMC_MODE_NOISE: wake_ok = conv_done || wdt_event || start_detect || nvm_ready || lvl ||
                                 pin_change || timer0_ovf || timer0_cmp;
      `SMC_MODE_PDOWN: wake_ok = wdt_event || start_detect || lvl || pin_change;
      default: wake_ok = wdt_event || start_detect || lvl || pin_change || t0;
    endcase
  endfunction : wake_ok

  // Start-up delay from clock source code
  function automatic logic [15:0] startup_cycles(input logic [3:0] fuses);
    startup_cycles = `SMC_STARTUP_UNIT * {12'h000, fuses} + `SMC_IRQ_HALT;
  endfunction : startup_cycles

  assign wake_req = wake_ok(mode, wake_cfg);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        if (paddr == `SMC_ADDR_SLEEP_CTRL) begin
          prdata <= {24'h000000, sleep_control_reg};
        end else if (paddr == `SMC_ADDR_CORE_CTRL) begin
          prdata <= {24'h000000, 1'b0, brownout_off_in_sleep_active, 6'h00};
        end else if (paddr == `SMC_ADDR_WAKE_CFG) begin
          prdata <= {24'h000000, wake_cfg};
        end else if (paddr == `SMC_ADDR_STATUS) begin
          prdata <= {24'h000000, bod_was_off, mode, 3'h0, state};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sleep_control_reg <= `SMC_SLEEP_CTRL_RST;
      wake_cfg          <= `SMC_WAKE_CFG_RST;
    end else if (wr_en && pready) begin
      if (paddr == `SMC_ADDR_SLEEP_CTRL) begin
        sleep_control_reg <= {5'h00, pwdata[2:0]};
      end else if (paddr == `SMC_ADDR_WAKE_CFG) begin
        wake_cfg <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brown-out disable timed sequence
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      unlock_cnt <= 3'h0;
    end else if (wr_en && pready && paddr == `SMC_ADDR_CORE_CTRL &&
                 core_wdata[`SMC_BROWNOUT_OFF_IN_SLEEP_BIT] && core_wdata[`SMC_BROWNOUT_OFF_UNLOCK_BIT]) begin
      unlock_cnt <= `SMC_UNLOCK_WIN;
    end else if (unlock_cnt != 3'h0) begin
      unlock_cnt <= unlock_cnt - 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      brownout_off_in_sleep <= 1'b0;
      brownout_off_in_sleep_cnt              <= 3'h0;
      brownout_off_in_sleep_active           <= 1'b0;
    end else if (wr_en && pready && paddr == `SMC_ADDR_CORE_CTRL && unlock_cnt != 3'h0 &&
                 core_wdata[`SMC_BROWNOUT_OFF_IN_SLEEP_BIT] && !core_wdata[`SMC_BROWNOUT_OFF_UNLOCK_BIT]) begin
      brownout_off_in_sleep <= 1'b1;
      brownout_off_in_sleep_cnt              <= `SMC_BROWNOUT_OFF_IN_SLEEP_DELAY;
      brownout_off_in_sleep_active           <= 1'b0;
    end else if (brownout_off_in_sleep) begin
      if (brownout_off_in_sleep_cnt != 3'h0) begin
        brownout_off_in_sleep_cnt <= brownout_off_in_sleep_cnt - 3'h1;
      end else if (!brownout_off_in_sleep_active) begin
        brownout_off_in_sleep_active <= 1'b1;
        brownout_off_in_sleep_cnt    <= `SMC_BROWNOUT_OFF_IN_SLEEP_HOLD - 3'h1;
      end else begin
        brownout_off_in_sleep_active           <= 1'b0;
        brownout_off_in_sleep <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep state machine; state is held, not cleared, across sleep
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state       <= smc_pkg::SMC_ACTIVE;
      mode        <= `SMC_MODE_IDLE;
      bod_was_off <= 1'b0;
      wake_cnt    <= 16'h0000;
    end else begin
      case (state)
        smc_pkg::SMC_ACTIVE: begin
          if (sleep_go) begin
            state       <= smc_pkg::SMC_SLEEP;
            mode        <= sleep_control_reg[`SMC_SM_LO +: 2];
            bod_was_off <= brownout_off_in_sleep_active && deep_mode;
          end
        end
        smc_pkg::SMC_SLEEP: begin
          if (wake_req || irq_pending) begin
            state <= smc_pkg::SMC_WAKE;
            if (bod_was_off) begin
              wake_cnt <= `SMC_BOD_WAKE_CYC;
            end else if (mode[1]) begin
              wake_cnt <= startup_cycles(clock_source_fuses);
            end else begin
              wake_cnt <= `SMC_IRQ_HALT;
            end
          end
        end
        smc_pkg::SMC_WAKE: begin
          if (wake_cnt <= 16'h0001) begin
            state       <= smc_pkg::SMC_ACTIVE;
            bod_was_off <= 1'b0;
          end else begin
            wake_cnt <= wake_cnt - 16'h0001;
          end
        end
        default: state <= smc_pkg::SMC_ACTIVE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock domain gating, registered outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      core_run               <= 1'b1;
      core_clock_domain      <= 1'b1;
      flash_clock_domain     <= 1'b1;
      io_clock_domain        <= 1'b1;
      converter_clock_domain <= 1'b1;
      async_clock_domain     <= 1'b1;
      main_osc_en            <= 1'b1;
      timer0_osc_en          <= 1'b1;
      brownout_detector_en   <= 1'b1;
    end else if (state == smc_pkg::SMC_SLEEP) begin
      core_run               <= 1'b0;
      core_clock_domain      <= 1'b0;
      flash_clock_domain     <= 1'b0;
      io_clock_domain        <= mode == `SMC_MODE_IDLE;
      converter_clock_domain <= !mode[1];
      async_clock_domain     <= mode != `SMC_MODE_PDOWN;
      main_osc_en            <= !mode[1];
      timer0_osc_en          <= mode != `SMC_MODE_PDOWN;
      brownout_detector_en   <= !bod_was_off;
    end else begin
      core_run               <= state == smc_pkg::SMC_ACTIVE;
      core_clock_domain      <= state == smc_pkg::SMC_ACTIVE;
      flash_clock_domain     <= state == smc_pkg::SMC_ACTIVE;
      io_clock_domain        <= 1'b1;
      converter_clock_domain <= 1'b1;
      async_clock_domain     <= 1'b1;
      main_osc_en            <= 1'b1;
      timer0_osc_en          <= 1'b1;
      brownout_detector_en   <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= sleep_go && !deep_mode && wake_cfg[`SMC_ADC_EN_BIT];
    end
  end

endmodule : smc_sleep_ctrl

// >>> smc_sleep_ctrl_asserts.sv
/*
 Port checker for the sleep mode controller.
 Assumes it is bound to every smc_sleep_ctrl instance.
*/
`timescale 1ns/1ps
module smc_sleep_asserts (
  // Clock, reset and bus
  input wire logic sys_clk, nrst, psel, penable, pready, pslverr,
  // Core and clock enables
  input wire logic sleep_instr, core_run, core_clock_domain, flash_clock_domain,
  input wire logic io_clock_domain, converter_clock_domain, main_osc_en,
  input wire logic brownout_detector_en, conv_start
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("ready missing in access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  a_no_slverr: assert property (pslverr == 1'b0) else $error("slave error raised");
  a_entry_cause: assert property ($fell(core_run) |-> $past(sleep_instr) || $past(sleep_instr, 2))
    else $error("core halted without sleep instruction");
  a_run_clocked: assert property (!core_clock_domain |-> !core_run) else $error("core runs unclocked");
  a_core_flash: assert property (core_clock_domain == flash_clock_domain) else $error("core flash split");
  a_io_first: assert property (!io_clock_domain |-> !core_clock_domain) else $error("io off core on");
  a_osc_deep: assert property (!main_osc_en |-> !io_clock_domain && !converter_clock_domain)
    else $error("clock runs without oscillator");
  a_conv_pulse: assert property (conv_start |=> !conv_start) else $error("conversion start too long");
  a_bod_deep: assert property (!brownout_detector_en |-> !main_osc_en) else $error("detector off shallow");
  a_bod_back: assert property ($rose(core_run) |-> brownout_detector_en) else $error("detector not back");
endmodule : smc_sleep_asserts

bind smc_sleep_ctrl smc_sleep_asserts u_chk (.sys_clk, .nrst, .psel, .penable, .pready, .pslverr,
  .sleep_instr, .core_run, .core_clock_domain, .flash_clock_domain, .io_clock_domain,
  .converter_clock_domain, .main_osc_en, .brownout_detector_en, .conv_start);

// >>> tb_smc_sleep_ctrl.sv
/*
 Testbench for the sleep mode controller: register access, sleep entry and wake runs.
 Assumes smc_defs.svh and the checker file are compiled alongside.
*/
`timescale 1ns/1ps
`include "smc_defs.svh"
module tb_smc_sleep_ctrl;
  localparam int FUSE = 1;
  localparam int DEEP = 64 * FUSE + 4;
  logic        sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, sleep_instr = 0, irq_pending = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic        pready, pslverr, core_run, brownout_detector_en, conv_start;
  logic [9:0]  src = '0;
  logic [6:0]  clks;
  logic [6:0]  clk_exp [4] = '{7'h1f, 7'h0f, 7'h00, 7'h05};
  int          err_count = 0, n_tests = 0, conv_seen = 0;

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (conv_start === 1'b1) conv_seen++;

  smc_sleep_ctrl u_dut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .sleep_instr, .irq_pending, .core_run, .ext_irq_zero(src[0]), .ext_irq_one(src[1]),
    .pin_change(src[2]), .wdt_event(src[3]), .start_detect(src[4]), .conv_done(src[5]),
    .nvm_ready(src[6]), .timer0_ovf(src[7]), .timer0_cmp(src[8]), .other_io_irq(src[9]),
    .clock_source_fuses(4'(FUSE)), .core_clock_domain(clks[6]), .flash_clock_domain(clks[5]),
    .io_clock_domain(clks[4]), .converter_clock_domain(clks[3]), .async_clock_domain(clks[2]),
    .main_osc_en(clks[1]), .timer0_osc_en(clks[0]), .brownout_detector_en, .conv_start);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    // Look at pready where it is settled, act on the next rising edge
    @(negedge sys_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      @(negedge sys_clk);
      n++;
    end
    if (n >= 20) err_count++;
    @(posedge sys_clk);
    r = prdata;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk("prdata", e, r);
    chk("pslverr", 0, pslverr);
  endtask : rd

  task automatic zzz;
    sleep_instr <= 1;
    @(posedge sys_clk);
    sleep_instr <= 0;
    repeat (4) @(posedge sys_clk);
  endtask : zzz

  // Sleep in mode m, raise source s, expect wake (ok) after dly cycles
  task automatic nap(input logic [1:0] m, input logic [7:0] cfg, input int s, ok, dly, brownout_detector);
    int n;
    n = 0;
    apb(1, `SMC_ADDR_WAKE_CFG, {24'h0, cfg});
    apb(1, `SMC_ADDR_SLEEP_CTRL, {29'h0, m, 1'b1});
    if (brownout_detector > 0) begin
      if (brownout_detector == 1) apb(1, `SMC_ADDR_CORE_CTRL, 32'h60);
      apb(1, `SMC_ADDR_CORE_CTRL, 32'h40);
      repeat (4) @(posedge sys_clk);
    end
    conv_seen = 0;
    zzz;
    chk("conv_start", cfg[6] && !m[1], conv_seen != 0);
    chk("clocks", clk_exp[m], clks);
    chk("bod_en", !(brownout_detector == 1 && m[1]), brownout_detector_en);
    src[s] <= 1;
    while (core_run !== 1'b1 && n < dly + 20) begin
      @(posedge sys_clk);
      n++;
    end
    chk("wake", ok, core_run);
    if (ok) chk("wake_delay", 1, n >= dly && n <= dly + 4);
    irq_pending <= 1;
    repeat (800) if (core_run !== 1'b1) @(posedge sys_clk);
    chk("bod_back", 1, brownout_detector_en);
    chk("clocks_on", 7'h7f, clks);
    src <= '0;
    irq_pending <= 0;
    apb(1, `SMC_ADDR_SLEEP_CTRL, 0);
    $display("test done mode %0d source %0d", m, s);
  endtask : nap

  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1;
    chk("clocks_reset", 7'h7f, clks);
    rd(`SMC_ADDR_SLEEP_CTRL, `SMC_SLEEP_CTRL_RST);
    rd(`SMC_ADDR_CORE_CTRL, `SMC_CORE_CTRL_RST);
    rd(`SMC_ADDR_WAKE_CFG, `SMC_WAKE_CFG_RST);
    apb(1, `SMC_ADDR_SLEEP_CTRL, 32'hff);
    rd(`SMC_ADDR_SLEEP_CTRL, 32'h07);
    apb(1, 12'h010, 32'hff);
    rd(12'h010, 0);
    apb(1, `SMC_ADDR_SLEEP_CTRL, 32'h04);
    zzz;
    chk("se_clear", 1, core_run);
    apb(1, `SMC_ADDR_CORE_CTRL, 32'h40);
    rd(`SMC_ADDR_CORE_CTRL, 0);
    $display("test done registers");
    nap(2'h0, 8'h40, 9, 1, 4, 0);
    nap(2'h1, 8'h00, 9, 0, 40, 0);
    nap(2'h1, 8'h40, 5, 1, 4, 0);
    nap(2'h2, 8'h40, 6, 0, DEEP, 0);
    nap(2'h2, 8'h13, 7, 0, DEEP, 0);
    nap(2'h2, 8'h00, 0, 0, DEEP, 0);
    nap(2'h2, 8'h00, 3, 1, DEEP, 0);
    nap(2'h3, 8'h13, 7, 1, DEEP, 0);
    nap(2'h3, 8'h0d, 1, 1, DEEP, 0);
    nap(2'h3, 8'h13, 8, 0, DEEP, 0);
    nap(2'h2, 8'h00, 4, 1, 600, 1);
    rd(`SMC_ADDR_CORE_CTRL, 0);
    nap(2'h2, 8'h00, 2, 1, DEEP, 2);
    nap(2'h0, 8'h00, 9, 1, 4, 1);
    apb(1, `SMC_ADDR_SLEEP_CTRL, 32'h05);
    zzz;
    chk("asleep", 0, core_run);
    nrst <= 0;
    @(posedge sys_clk);
    chk("reset_wake", 1, core_run);
    nrst <= 1;
    rd(`SMC_ADDR_SLEEP_CTRL, 0);
    $display("test done reset in sleep");
    test_done;
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    test_done;
  end
endmodule : tb_smc_sleep_ctrl
